/* File: logic/pig_irq_map.vh */
`ifndef PIG_IRQ_MAP_VH
`define PIG_IRQ_MAP_VH

// ****************************************************************
// Register byte addresses
// ****************************************************************
`define PIG_ADDR_W          12
`define PIG_ADDR_CTRL       12'h000
`define PIG_ADDR_EN1        12'h004
`define PIG_ADDR_EN2        12'h008
`define PIG_ADDR_EN3        12'h00C
`define PIG_ADDR_FLG3       12'h010
`define PIG_ADDR_STAT       12'h014

// ****************************************************************
// Reset values and implemented-bit masks
// ****************************************************************
`define PIG_RST_CTRL        2'h0
`define PIG_RST_EN          8'h00
`define PIG_RST_FLG3        5'h00
`define PIG_MASK_EN1        8'h7F
`define PIG_MASK_EN2        8'h95
`define PIG_MASK_EN3        8'h1F
`define PIG_ZERO_DATA       32'h00000000

// ****************************************************************
// Field positions
// ****************************************************************
`define PIG_CTRL_PRIO_BIT   0
`define PIG_CTRL_GIE_BIT    1
`define PIG_EN1_CONV_BIT    6
`define PIG_EN1_SRX_BIT     5
`define PIG_EN1_STX_BIT     4
`define PIG_EN1_SSP_BIT     3
`define PIG_EN1_CC1_BIT     2
`define PIG_EN1_TMB_BIT     1
`define PIG_EN1_TMA_BIT     0
`define PIG_EN1_TOP_BIT     7
`define PIG_EN2_CLKF_BIT    7
`define PIG_EN2_NVM_BIT     4
`define PIG_EN2_LVD_BIT     2
`define PIG_EN2_CC2_BIT     0
`define PIG_F3_PWMB_BIT     4
`define PIG_F3_CAP3_BIT     3
`define PIG_F3_CAP2_BIT     2
`define PIG_F3_CAP1_BIT     1
`define PIG_F3_TME_BIT      0
`define PIG_FLG3_W          5
`define PIG_STAT_REQ_BIT    0
`define PIG_STAT_GATE_BIT   1
`define PIG_STAT_P1_LSB     8
`define PIG_STAT_P2_LSB     16
`define PIG_STAT_P3_LSB     24

`endif

/* File: logic/pig_sticky_flags.v */
`timescale 1ns/1ps
`default_nettype none
`include "pig_irq_map.vh"

// ****************************************************************
// Software-cleared request flags, event set wins over a write
// ****************************************************************
module pig_sticky_flags
(
  input  wire                    pclk,
  input  wire                    presetn,
  input  wire                    wr_en,
  input  wire [`PIG_FLG3_W-1:0]  wr_data,
  input  wire [`PIG_FLG3_W-1:0]  set_evt,
  output wire [`PIG_FLG3_W-1:0]  flags
);

  reg  [`PIG_FLG3_W-1:0] flag_r;
  wire [`PIG_FLG3_W-1:0] flag_nxt;

  genvar gi;
  generate
    for (gi = 0; gi < `PIG_FLG3_W; gi = gi + 1)
    begin : g_flag
      // Only an event or software changes a flag
      assign flag_nxt[gi] = set_evt[gi] | (wr_en ? wr_data[gi] : flag_r[gi]); // [RULE_11]
    end
  endgenerate

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      flag_r <= `PIG_RST_FLG3;
    end
    else
    begin
      flag_r <= flag_nxt;
    end
  end

  assign flags = flag_r;

endmodule // pig_sticky_flags

`default_nettype wire

/* File: logic/pig_irq_gate.v */
// How it works
// RULE_01: Without priority mode, nothing reaches the core unless the global peripheral enable is set.
// RULE_02: Three enable registers, one enable bit per peripheral source.
// RULE_03: Enable-1 bit 6 gates the converter-complete request.
// RULE_04: Enable-1 bit 5 gates the serial receive request.
// RULE_05: Enable-1 bit 4 gates the serial transmit request.
// RULE_06: Enable-1 bit 3 gates the synchronous serial port request.
// RULE_07: Enable-1 bit 2 gates the first capture/compare unit request.
// RULE_08: Enable-1 bit 1 gates the second timer period-match request.
// RULE_09: Enable-1 bit 0 gates the first timer overflow request.
// RULE_10: Enable-1 bit 7 ignores writes and reads as zero.
// RULE_11: Flag-3 bits stay set until software clears them.
// RULE_12: Request goes out when any enabled flag is set, after global gating.
`timescale 1ns/1ps
`default_nettype none
`include "pig_irq_map.vh"

module pig_irq_gate
(
  input  wire                    pclk,
  input  wire                    presetn,
  input  wire                    psel,
  input  wire                    penable,
  input  wire                    pwrite,
  input  wire [`PIG_ADDR_W-1:0]  paddr,
  input  wire [31:0]             pwdata,
  output wire [31:0]             prdata,
  output wire                    pready,
  output wire                    pslverr,
  input  wire [6:0]              src1_req,
  input  wire [7:0]              src2_req,
  input  wire [4:0]              flag3_set,
  output wire [4:0]              flag3_state,
  output wire                    periph_irq_req
);

  // ****************************************************************
  // Address decoding
  // ****************************************************************
  function addr_is;
    input [`PIG_ADDR_W-1:0] a;
    input [`PIG_ADDR_W-1:0] target;
    begin
      addr_is = (a == target);
    end
  endfunction

  function addr_mapped;
    input [`PIG_ADDR_W-1:0] a;
    begin
      addr_mapped = addr_is(a, `PIG_ADDR_CTRL) |
                    addr_is(a, `PIG_ADDR_EN1)  |
                    addr_is(a, `PIG_ADDR_EN2)  |
                    addr_is(a, `PIG_ADDR_EN3)  |
                    addr_is(a, `PIG_ADDR_FLG3) |
                    addr_is(a, `PIG_ADDR_STAT);
    end
  endfunction

  // ****************************************************************
  // Bus phases
  // ****************************************************************
  wire setup_ph;
  wire wr_acc;
  wire wr_ctrl;
  wire wr_en1;
  wire wr_en2;
  wire wr_en3;
  wire wr_flg3;

  assign setup_ph = psel & ~penable;
  // Status is read-only: a write to it is dropped
  // Writes land only on the completing access edge
  assign wr_acc   = psel & penable & pready & pwrite & addr_mapped(paddr);
  assign wr_ctrl  = wr_acc & addr_is(paddr, `PIG_ADDR_CTRL);
  assign wr_en1   = wr_acc & addr_is(paddr, `PIG_ADDR_EN1);
  assign wr_en2   = wr_acc & addr_is(paddr, `PIG_ADDR_EN2);
  assign wr_en3   = wr_acc & addr_is(paddr, `PIG_ADDR_EN3);
  assign wr_flg3  = wr_acc & addr_is(paddr, `PIG_ADDR_FLG3);

  // Zero wait states
  assign pready = 1'b1;

  // ****************************************************************
  // Control register: priority mode and global peripheral enable
  // ****************************************************************
  reg  [1:0] ctrl_r;
  wire [1:0] ctrl_nxt;

  assign ctrl_nxt = wr_ctrl ? pwdata[1:0] : ctrl_r;

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_r <= `PIG_RST_CTRL;
    end
    else
    begin
      ctrl_r <= ctrl_nxt;
    end
  end

  wire priority_mode_enable;
  wire periph_global_irq_enable;

  assign priority_mode_enable     = ctrl_r[`PIG_CTRL_PRIO_BIT];
  assign periph_global_irq_enable = ctrl_r[`PIG_CTRL_GIE_BIT];

  // ****************************************************************
  // Enable registers
  // ****************************************************************
  reg  [7:0] en1_r;
  reg  [7:0] en2_r;
  reg  [7:0] en3_r;
  wire [7:0] en1_nxt;
  wire [7:0] en2_nxt;
  wire [7:0] en3_nxt;

  // Unimplemented top bit never stores
  assign en1_nxt = wr_en1 ? (pwdata[7:0] & `PIG_MASK_EN1) : en1_r; // [RULE_10]
  assign en2_nxt = wr_en2 ? (pwdata[7:0] & `PIG_MASK_EN2) : en2_r; // [RULE_02]
  assign en3_nxt = wr_en3 ? (pwdata[7:0] & `PIG_MASK_EN3) : en3_r; // [RULE_02]

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      en1_r <= `PIG_RST_EN;
      en2_r <= `PIG_RST_EN;
      en3_r <= `PIG_RST_EN;
    end
    else
    begin
      en1_r <= en1_nxt; // [RULE_02]
      en2_r <= en2_nxt;
      en3_r <= en3_nxt;
    end
  end

  wire peripheral_irq_enable_1_top;
  wire converter_irq_enable;
  wire serial_rx_irq_enable;
  wire serial_tx_irq_enable;
  wire sync_serial_irq_enable;
  wire capcmp_unit1_irq_enable;
  wire timer_b_match_irq_enable;
  wire timer_a_overflow_irq_enable;

  assign peripheral_irq_enable_1_top = en1_r[`PIG_EN1_TOP_BIT];
  assign converter_irq_enable        = en1_r[`PIG_EN1_CONV_BIT];
  assign serial_rx_irq_enable        = en1_r[`PIG_EN1_SRX_BIT];
  assign serial_tx_irq_enable        = en1_r[`PIG_EN1_STX_BIT];
  assign sync_serial_irq_enable      = en1_r[`PIG_EN1_SSP_BIT];
  assign capcmp_unit1_irq_enable     = en1_r[`PIG_EN1_CC1_BIT];
  assign timer_b_match_irq_enable    = en1_r[`PIG_EN1_TMB_BIT];
  assign timer_a_overflow_irq_enable = en1_r[`PIG_EN1_TMA_BIT];

  // ****************************************************************
  // Enable-2 and enable-3 fields
  // ****************************************************************
  // Enable-2 bits 6, 5, 3 and 1 never store
  wire clock_fail_irq_enable;
  wire nvm_write_irq_enable;
  wire low_volt_irq_enable;
  wire capcmp_unit2_irq_enable;

  assign clock_fail_irq_enable   = en2_r[`PIG_EN2_CLKF_BIT];
  assign nvm_write_irq_enable    = en2_r[`PIG_EN2_NVM_BIT];
  assign low_volt_irq_enable     = en2_r[`PIG_EN2_LVD_BIT];
  assign capcmp_unit2_irq_enable = en2_r[`PIG_EN2_CC2_BIT];

  wire pwm_base_irq_enable;
  wire capture3_dir_irq_enable;
  wire capture2_pos_irq_enable;
  wire capture1_vel_irq_enable;
  wire timer_e_match_irq_enable;

  assign pwm_base_irq_enable      = en3_r[`PIG_F3_PWMB_BIT];
  assign capture3_dir_irq_enable  = en3_r[`PIG_F3_CAP3_BIT];
  assign capture2_pos_irq_enable  = en3_r[`PIG_F3_CAP2_BIT];
  assign capture1_vel_irq_enable  = en3_r[`PIG_F3_CAP1_BIT];
  assign timer_e_match_irq_enable = en3_r[`PIG_F3_TME_BIT];

  // ****************************************************************
  // Third request-flag register
  // ****************************************************************
  wire [4:0] flg3;

  pig_sticky_flags u_flags3 // [RULE_11]
  (
    .pclk    (pclk),
    .presetn (presetn),
    .wr_en   (wr_flg3),
    .wr_data (pwdata[4:0]),
    .set_evt (flag3_set),
    .flags   (flg3)
  );

  wire pwm_timebase_flag;
  wire capture3_direction_flag;
  wire capture2_or_position_flag;
  wire capture1_velocity_flag;
  wire timer_e_match_flag;

  assign pwm_timebase_flag         = flg3[`PIG_F3_PWMB_BIT];
  assign capture3_direction_flag   = flg3[`PIG_F3_CAP3_BIT];
  assign capture2_or_position_flag = flg3[`PIG_F3_CAP2_BIT];
  assign capture1_velocity_flag    = flg3[`PIG_F3_CAP1_BIT];
  assign timer_e_match_flag        = flg3[`PIG_F3_TME_BIT];
  assign flag3_state               = flg3;

  // ****************************************************************
  // Per-source gating
  // ****************************************************************
  wire [6:0] pend1;
  wire [7:0] pend2;
  wire [4:0] pend3;

  assign pend1[6] = src1_req[6] & converter_irq_enable;        // [RULE_03]
  assign pend1[5] = src1_req[5] & serial_rx_irq_enable;        // [RULE_04]
  assign pend1[4] = src1_req[4] & serial_tx_irq_enable;        // [RULE_05]
  assign pend1[3] = src1_req[3] & sync_serial_irq_enable;      // [RULE_06]
  assign pend1[2] = src1_req[2] & capcmp_unit1_irq_enable;     // [RULE_07]
  assign pend1[1] = src1_req[1] & timer_b_match_irq_enable;    // [RULE_08]
  assign pend1[0] = src1_req[0] & timer_a_overflow_irq_enable; // [RULE_09]

  // Unimplemented enable-2 bits hold zero, so they never pend
  assign pend2[7]   = src2_req[7] & clock_fail_irq_enable;   // [RULE_02]
  assign pend2[6:5] = src2_req[6:5] & en2_r[6:5];
  assign pend2[4]   = src2_req[4] & nvm_write_irq_enable;    // [RULE_02]
  assign pend2[3]   = src2_req[3] & en2_r[3];
  assign pend2[2]   = src2_req[2] & low_volt_irq_enable;     // [RULE_02]
  assign pend2[1]   = src2_req[1] & en2_r[1];
  assign pend2[0]   = src2_req[0] & capcmp_unit2_irq_enable; // [RULE_02]

  // Flag-3 requests stay pending until software clears them
  assign pend3[4] = pwm_timebase_flag & pwm_base_irq_enable;             // [RULE_12]
  assign pend3[3] = capture3_direction_flag & capture3_dir_irq_enable;   // [RULE_12]
  assign pend3[2] = capture2_or_position_flag & capture2_pos_irq_enable; // [RULE_12]
  assign pend3[1] = capture1_velocity_flag & capture1_vel_irq_enable;    // [RULE_12]
  assign pend3[0] = timer_e_match_flag & timer_e_match_irq_enable;       // [RULE_12]

  // ****************************************************************
  // Request to the core
  // ****************************************************************
  wire any_pend;
  wire gate_open;
  reg  irq_req_r;
  wire irq_req_nxt;

  assign any_pend    = (|pend1) | (|pend2) | (|pend3); // [RULE_12]
  // Priority mode hands gating to the core's priority logic
  assign gate_open   = priority_mode_enable | periph_global_irq_enable; // [RULE_01]
  assign irq_req_nxt = any_pend & gate_open; // [RULE_12]

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq_req_r <= 1'b0;
    end
    else
    begin
      irq_req_r <= irq_req_nxt;
    end
  end

  assign periph_irq_req = irq_req_r;

  // ****************************************************************
  // Read data, captured in the setup cycle
  // ****************************************************************
  reg  [31:0] rd_nxt;
  reg  [31:0] prdata_r;
  reg         pslverr_r;
  wire        err_nxt;

  // A flag change between setup and access is not seen
  always @*
  begin
    rd_nxt = `PIG_ZERO_DATA;
    case (paddr)
      `PIG_ADDR_CTRL:
      begin
        rd_nxt[1:0] = ctrl_r;
      end
      `PIG_ADDR_EN1:
      begin
        rd_nxt[6:0] = en1_r[6:0];
        rd_nxt[`PIG_EN1_TOP_BIT] = 1'b0; // [RULE_10]
      end
      `PIG_ADDR_EN2:
      begin
        rd_nxt[7:0] = en2_r;
      end
      `PIG_ADDR_EN3:
      begin
        rd_nxt[7:0] = en3_r;
      end
      `PIG_ADDR_FLG3:
      begin
        rd_nxt[4:0] = flg3;
      end
      `PIG_ADDR_STAT:
      begin
        rd_nxt[`PIG_STAT_REQ_BIT]            = irq_req_r;
        rd_nxt[`PIG_STAT_GATE_BIT]           = gate_open;
        rd_nxt[`PIG_STAT_P1_LSB+6:`PIG_STAT_P1_LSB] = pend1;
        rd_nxt[`PIG_STAT_P2_LSB+7:`PIG_STAT_P2_LSB] = pend2;
        rd_nxt[`PIG_STAT_P3_LSB+4:`PIG_STAT_P3_LSB] = pend3;
      end
      default:
      begin
        rd_nxt = `PIG_ZERO_DATA;
      end
    endcase
  end

  assign err_nxt = ~addr_mapped(paddr);

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_r  <= `PIG_ZERO_DATA;
      pslverr_r <= 1'b0;
    end
    else if (setup_ph)
    begin
      prdata_r  <= pwrite ? `PIG_ZERO_DATA : rd_nxt;
      pslverr_r <= err_nxt;
    end
  end

  assign prdata  = prdata_r;
  assign pslverr = pslverr_r & psel & penable;

endmodule // pig_irq_gate

`default_nettype wire

/* File: tb/pig_irq_checker.sv */
`timescale 1ns/1ps
`default_nettype none
`include "pig_irq_map.vh"

module pig_irq_checker
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [6:0]  src1_req,
  input wire logic [7:0]  src2_req,
  input wire logic [4:0]  flag3_set,
  input wire logic [4:0]  flag3_state,
  input wire logic        periph_irq_req
);
  logic [1:0] ctrl_r;
  logic [6:0] en1_r;
  logic [7:0] en2_r;
  logic [4:0] en3_r;
  wire        acc_w  = psel & penable & pready;
  wire        wr_w   = acc_w & pwrite;
  wire        wr_flg = wr_w & (paddr == `PIG_ADDR_FLG3);
  wire        rd_en1 = acc_w & !pwrite & (paddr == `PIG_ADDR_EN1);
  wire [4:0]  wd5    = pwdata[4:0];
  wire        pend   = |{src1_req & en1_r, src2_req & en2_r, flag3_state & en3_r};
  wire        exp_req = pend & (ctrl_r != 2'h0);

  // ****************************************************************
  // Shadow of the control and enable registers
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      ctrl_r <= 2'h0;
      en1_r  <= 7'h00;
      en2_r  <= 8'h00;
      en3_r  <= 5'h00;
    end
    else if (wr_w)
    begin
      if (paddr == `PIG_ADDR_CTRL) ctrl_r <= pwdata[1:0];
      if (paddr == `PIG_ADDR_EN1) en1_r <= pwdata[6:0];
      if (paddr == `PIG_ADDR_EN2) en2_r <= pwdata[7:0] & `PIG_MASK_EN2;
      if (paddr == `PIG_ADDR_EN3) en3_r <= pwdata[4:0];
    end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_GLOBAL_GATE: assert property (ctrl_r == 2'h0 |=> !periph_irq_req)
    else $error("request raised with gate closed");
  AST_REQ_FOLLOWS: assert property (periph_irq_req == $past(exp_req))
    else $error("request differs from enabled pending sources");
  AST_FLAG_HOLD: assert property (!wr_flg |=>
    (flag3_state & $past(flag3_state)) == $past(flag3_state))
    else $error("flag cleared without a write");
  AST_FLAG_SET: assert property (flag3_set != 5'h00 |=>
    (flag3_state & $past(flag3_set)) == $past(flag3_set))
    else $error("set event did not set its flag");
  AST_FLAG_WRITE: assert property (wr_flg && flag3_set == 5'h00 |=>
    flag3_state == $past(wd5))
    else $error("flag write not stored");
  AST_EN1_TOP: assert property (rd_en1 |-> prdata[31:7] == 25'h0000000)
    else $error("enable-1 top bit reads nonzero");
  AST_EN1_READ: assert property (rd_en1 |-> prdata[6:0] == en1_r)
    else $error("enable-1 read value wrong");
  AST_SLVERR: assert property (psel && penable && paddr[1:0] == 2'h0 |->
    pslverr == (paddr > `PIG_ADDR_STAT))
    else $error("error response wrong for address");
endmodule // pig_irq_checker

bind pig_irq_gate pig_irq_checker u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .src1_req(src1_req), .src2_req(src2_req),
  .flag3_set(flag3_set), .flag3_state(flag3_state), .periph_irq_req(periph_irq_req));

`default_nettype wire

/* File: tb/pig_periph_model.sv */
`timescale 1ns/1ps
`default_nettype none

module pig_periph_model
(
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic [6:0] lvl1,
  input  wire logic [7:0] lvl2,
  input  wire logic [4:0] evt,
  output var  logic [6:0] src1_req,
  output var  logic [7:0] src2_req,
  output var  logic [4:0] flag3_set
);
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      src1_req  <= 7'h00;
      src2_req  <= 8'h00;
      flag3_set <= 5'h00;
    end
    else
    begin
      src1_req  <= lvl1;
      src2_req  <= lvl2;
      flag3_set <= evt;
    end
endmodule // pig_periph_model

`default_nettype wire

/* File: tb/peripheral_irq_enable_gating_bench.sv */
`timescale 1ns/1ps
`default_nettype none
`include "pig_irq_map.vh"

module peripheral_irq_enable_gating_bench;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [6:0]  lvl1 = 7'h00;
  logic [7:0]  lvl2 = 8'h00;
  logic [4:0]  evt = 5'h00;
  wire  [31:0] prdata;
  wire         pready, pslverr, periph_irq_req;
  wire  [6:0]  src1_req;
  wire  [7:0]  src2_req;
  wire  [4:0]  flag3_set, flag3_state;
  logic [31:0] rd;
  logic        se;
  int          n_mismatch = 0;
  int          tests_run = 0;
  int          cyc = 0;

  always #4 pclk = ~pclk;

  pig_irq_gate dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .src1_req(src1_req), .src2_req(src2_req), .flag3_set(flag3_set),
    .flag3_state(flag3_state), .periph_irq_req(periph_irq_req));
  pig_periph_model u_per (.pclk(pclk), .presetn(presetn), .lvl1(lvl1), .lvl2(lvl2),
    .evt(evt), .src1_req(src1_req), .src2_req(src2_req), .flag3_set(flag3_set));

  task wrap_up;
    if (n_mismatch == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      n_mismatch++;
      wrap_up;
    end
  end

  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task tick(input int n);
    repeat (n) @(posedge pclk);
  endtask

  // ****************************************************************
  // Bus cycles: setup, then access until pready
  // ****************************************************************
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task reqs(input logic [6:0] a, input logic [7:0] b);
    lvl1 <= a;
    lvl2 <= b;
    tick(4);
  endtask

  initial
  begin
    tick(20);
    presetn <= 1'b1;
    apb(0, `PIG_ADDR_EN1, 0);
    chk("en1 reset", rd, 32'h00);
    chk("pready", pready, 1);
    apb(1, `PIG_ADDR_EN1, 32'hFFFFFFFF);
    apb(0, `PIG_ADDR_EN1, 0);
    chk("en1 mask", rd, 32'h7F);
    apb(1, `PIG_ADDR_EN2, 32'hFFFFFFFF);
    apb(0, `PIG_ADDR_EN2, 0);
    chk("en2", rd, {24'h000000, `PIG_MASK_EN2});
    apb(0, 12'h020, 0);
    chk("unmapped err", se, 1);
    chk("unmapped data", rd, 0);
    reqs(7'h7F, 8'h00);
    chk("irq gate shut", periph_irq_req, 0);
    apb(1, `PIG_ADDR_CTRL, 1);
    tick(2);
    chk("irq prio", periph_irq_req, 1);
    apb(1, `PIG_ADDR_CTRL, 2);
    tick(2);
    chk("irq global", periph_irq_req, 1);
    for (int i = 0; i < 7; i++)
    begin
      apb(1, `PIG_ADDR_EN1, 32'h7F ^ (32'h1 << i));
      reqs(7'h01 << i, 8'h00);
      chk("irq bit off", periph_irq_req, 0);
      apb(1, `PIG_ADDR_EN1, 32'h1 << i);
      tick(2);
      chk("irq bit on", periph_irq_req, 1);
    end
    apb(1, `PIG_ADDR_EN1, 0);
    reqs(7'h00, 8'h80);
    chk("irq en2", periph_irq_req, 1);
    apb(0, `PIG_ADDR_STAT, 0);
    chk("status", rd, 32'h00800003);
    reqs(7'h00, 8'h00);
    apb(1, `PIG_ADDR_EN3, 32'h1F);
    evt <= 5'h01;
    tick(1);
    evt <= 5'h00;
    tick(20);
    apb(0, `PIG_ADDR_FLG3, 0);
    chk("flag sticky", rd, 32'h01);
    chk("irq flag", periph_irq_req, 1);
    evt <= 5'h02;
    apb(1, `PIG_ADDR_FLG3, 0);
    evt <= 5'h00;
    tick(2);
    chk("flag set wins", flag3_state, 32'h02);
    apb(1, `PIG_ADDR_FLG3, 0);
    tick(2);
    chk("flag clr", flag3_state, 0);
    chk("irq flag clr", periph_irq_req, 0);
    presetn <= 1'b0;
    tick(2);
    presetn <= 1'b1;
    apb(0, `PIG_ADDR_EN3, 0);
    chk("en3 reset", rd, 0);
    chk("irq after reset", periph_irq_req, 0);
    wrap_up;
  end
endmodule // peripheral_irq_enable_gating_bench

`default_nettype wire
